/* File: host_dma_extent_sequencer_map.vh */
// register map, field positions and configuration constants for the host dma extent sequencer
// How it works
// RULE1 - chan field selects extents zero up to three
// RULE2 - autoform clear means transfer unconditionally
// RULE3 - form mismatch reloads pointers instead of transferring
// RULE4 - last form is lsb of header byte 12
// RULE5 - reload at count zero when flag set
// RULE6 - reload clears one flag; 00 makes extent three
// RULE7 - hostblock write starts one programmed part
// RULE8 - software writes 3 or 4 to config
// RULE9 - chip select low for FFC0H to FFDFH
// RULE10 - only multiplexed address data bus supported
// RULE11 - normal and burst dma, eight bits each
// RULE12 - clearing dma enable halts generic transfers
// RULE13 - normal dma: mode bit clear, enable set
// RULE14 - normal: byte per request, ack toggles per byte
// RULE15 - burst: ack held, strobe toggles per byte
// RULE16 - burst dma: mode and enable bits set
// RULE17 - software accesses wide registers high byte first
// RULE18 - high read snapshots low byte into holding
// RULE19 - high write held, low write updates both
// RULE20 - one holding register overwritten by range accesses
// RULE21 - interrupt code saves and restores holding register
// RULE22 - holding register readable writable at FF6FH
`ifndef HOST_DMA_EXTENT_SEQUENCER_MAP_VH
`define HOST_DMA_EXTENT_SEQUENCER_MAP_VH
`define A_CURSEG_H    16'hFF44
`define A_CURSEG_L    16'hFF45
`define A_CURSEGCNT   16'hFF66
`define A_OFS0_H      16'hFF58
`define A_OFS0_L      16'hFF59
`define A_OFS1_H      16'hFF5C
`define A_OFS1_L      16'hFF5D
`define A_OFS2_H      16'hFF50
`define A_OFS2_L      16'hFF51
`define A_NEXTSEG_H   16'hFF54
`define A_NEXTSEG_L   16'hFF55
`define A_NEXTSEGCNT  16'hFF57
`define A_RELFLAGS    16'hFF56
`define A_BOFS_H      16'hFF42
`define A_BOFS_L      16'hFF43
`define A_BCNT_H      16'hFF64
`define A_BCNT_L      16'hFF65
`define A_RELSEG_H    16'hFF68
`define A_RELSEG_L    16'hFF69
`define A_RELOADCNT   16'hFF6A
`define A_HOLD        16'hFF6F
`define A_HOSTBLOCK   16'hFF6C
`define A_HOST_CONFIG_ONE     16'hFF6D
`define A_TRANSFER_CONTROL_REGISTER       16'hFF6E
`define A_CONFIG      16'hFF86
`define HOLD_LO       16'hFF20
`define HOLD_HI       16'hFF6F
`define CS_LO         16'hFFC0
`define CS_HI         16'hFFDF
`define B_AUTOFORM    7
`define B_FORM        6
`define B_DMAEN       7
`define B_DMAMODE     6
`define B_DMA         5
`define B_REL1        7
`define B_REL2        6
`define FORM_OFS      12'h00C
`define CFG_8BIT      8'h03
`endif

/* File: host_dma_extent_sequencer.v */
// host dma extent sequencer: extent walk, form check, pointer reload, generic dma
`timescale 1ns/1ps
`default_nettype none
`include "host_dma_extent_sequencer_map.vh"
module host_dma_extent_sequencer #(
  parameter BUF_AW = 24
) (
  input  wire              clk_sys,
  input  wire              nrst,
  input  wire              cpu_wr,       // one-cycle register write strobe
  input  wire              cpu_rd,       // one-cycle register read strobe
  input  wire [15:0]       cpu_addr,     // demultiplexed sub-cpu address
  input  wire [7:0]        cpu_wdata,
  output reg  [7:0]        cpu_rdata,    // read data, valid cycle after cpu_rd
  output reg               scsi_cs_n,    // external controller chip select
  input  wire              dmarq,        // request from external controller (pin)
  output reg               dmack,        // dma acknowledge
  output reg               dma_read_strobe,
  output reg               dma_write_strobe,
  output reg               buf_rd,       // buffer byte fetch pulse
  output reg  [BUF_AW-1:0] buf_addr,     // buffer byte address
  input  wire [7:0]        buf_rdata,    // buffer data, same clock
  output reg               part_done     // pulse when byte count reaches zero
);
  // one-hot states
  localparam S_IDLE = 4'b0001;
  localparam S_FORM = 4'b0010;
  localparam S_XFER = 4'b0100;
  localparam S_NEXT = 4'b1000;

  reg [12:0] curseg_q;     // current segment pointer
  reg [1:0]  chan_q;       // extent count select
  reg [7:0]  cursegcnt_q;  // current segment count
  reg [15:0] ofs_q [0:2];  // sub-block offsets with form bits
  reg [15:0] nextseg_q;    // next segment pointer / extent 3 offset
  reg [7:0]  nextsegcnt_q; // next segment count
  reg [7:0]  relflags_q;   // reload flags
  reg [15:0] bofs_q;       // byte offset
  reg [11:0] bcnt_q;       // byte count
  reg [15:0] relseg_q;     // reload segment pointer
  reg [7:0]  reloadcnt_q;  // reload count
  reg [7:0]  hold_q;       // shared holding byte
  reg [7:0]  hiconf_q;     // dma enable
  reg [7:0]  transfer_control_register_q;      // dma mode
  reg [7:0]  config_q;     // host interface config
  reg [3:0]  st_q;         // sequencer state
  reg [1:0]  ext_q;        // current extent
  reg        form_q;       // last form bit
  reg        rq_s1_q;      // request synchroniser
  reg        rq_s2_q;
  reg [1:0]  ph_q;         // handshake phase

  wire in_hold = (cpu_addr >= `HOLD_LO) && (cpu_addr <= `HOLD_HI);
  wire dma_on  = hiconf_q[`B_DMAEN] && transfer_control_register_q[`B_DMA];            // [RULE12]
  wire burst   = transfer_control_register_q[`B_DMAMODE];                               // [RULE11]
  // active extent offset; extent 3 is the next segment pointer
  wire [15:0] ext_ofs = (ext_q == 2'd3) ? nextseg_q : ofs_q[ext_q];
  wire ext3_ok = (relflags_q[`B_REL1:`B_REL2] == 2'b00);           // [RULE6]

  // read mux
  reg [7:0] rd_d;
  always @* begin
    case (cpu_addr)
      `A_CURSEG_H:   rd_d = {chan_q, 1'b0, curseg_q[12:8]};
      `A_CURSEGCNT:  rd_d = cursegcnt_q;
      `A_OFS0_H:     rd_d = ofs_q[0][15:8];
      `A_OFS1_H:     rd_d = ofs_q[1][15:8];
      `A_OFS2_H:     rd_d = ofs_q[2][15:8];
      `A_NEXTSEG_H:  rd_d = nextseg_q[15:8];
      `A_NEXTSEGCNT: rd_d = nextsegcnt_q;
      `A_RELFLAGS:   rd_d = relflags_q;
      `A_BOFS_H:     rd_d = bofs_q[15:8];
      `A_BCNT_H:     rd_d = {4'h0, bcnt_q[11:8]};
      `A_RELSEG_H:   rd_d = relseg_q[15:8];
      `A_RELOADCNT:  rd_d = reloadcnt_q;
      `A_HOST_CONFIG_ONE:    rd_d = hiconf_q;
      `A_TRANSFER_CONTROL_REGISTER:      rd_d = transfer_control_register_q;
      `A_CONFIG:     rd_d = config_q;
      default:       rd_d = hold_q;   // low bytes and FF6F return holding [RULE18] [RULE22]
    endcase
  end

  // low-byte snapshot for a high-byte read
  reg [7:0] lo_d;
  always @* begin
    case (cpu_addr)
      `A_CURSEG_H:  lo_d = curseg_q[7:0];
      `A_OFS0_H:    lo_d = ofs_q[0][7:0];
      `A_OFS1_H:    lo_d = ofs_q[1][7:0];
      `A_OFS2_H:    lo_d = ofs_q[2][7:0];
      `A_NEXTSEG_H: lo_d = nextseg_q[7:0];
      `A_BOFS_H:    lo_d = bofs_q[7:0];
      `A_BCNT_H:    lo_d = bcnt_q[7:0];
      `A_RELSEG_H:  lo_d = relseg_q[7:0];
      default:      lo_d = rd_d;
    endcase
  end

  // synchroniser for the external request pin
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rq_s1_q <= 1'b0;
      rq_s2_q <= 1'b0;
    end else begin
      rq_s1_q <= dmarq;
      rq_s2_q <= rq_s1_q;
    end
  end

  // register file, sequencer and dma handshake
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      curseg_q <= 13'h0000; chan_q <= 2'b00; cursegcnt_q <= 8'h00;
      ofs_q[0] <= 16'h0000; ofs_q[1] <= 16'h0000; ofs_q[2] <= 16'h0000;
      nextseg_q <= 16'h0000; nextsegcnt_q <= 8'h00; relflags_q <= 8'h00;
      bofs_q <= 16'h0000; bcnt_q <= 12'h000; relseg_q <= 16'h0000;
      reloadcnt_q <= 8'h00; hold_q <= 8'h00; hiconf_q <= 8'h00;
      transfer_control_register_q <= 8'h00; config_q <= 8'h00; st_q <= S_IDLE; ext_q <= 2'd0;
      form_q <= 1'b0; ph_q <= 2'd0; cpu_rdata <= 8'h00; scsi_cs_n <= 1'b1;
      dmack <= 1'b0; dma_read_strobe <= 1'b0; dma_write_strobe <= 1'b0;
      buf_rd <= 1'b0; buf_addr <= {BUF_AW{1'b0}}; part_done <= 1'b0;
    end else begin
      buf_rd <= 1'b0;
      part_done <= 1'b0;
      // chip select for window, multiplexed bus only [RULE9] [RULE10]
      scsi_cs_n <= ~((cpu_rd || cpu_wr) && (cpu_addr >= `CS_LO) && (cpu_addr <= `CS_HI));
      if (cpu_rd) begin
        cpu_rdata <= rd_d;
        if (in_hold && cpu_addr != `A_HOLD)
          hold_q <= lo_d;                                           // [RULE18] [RULE20]
      end
      if (cpu_wr) begin
        if (in_hold)
          hold_q <= cpu_wdata;                                      // [RULE19] [RULE20]
        case (cpu_addr)
          `A_CURSEG_L:   {chan_q, curseg_q} <= {hold_q[7:6], hold_q[4:0], cpu_wdata}; // [RULE19]
          `A_CURSEGCNT:  cursegcnt_q <= cpu_wdata;
          `A_OFS0_L:     ofs_q[0] <= {hold_q, cpu_wdata};
          `A_OFS1_L:     ofs_q[1] <= {hold_q, cpu_wdata};
          `A_OFS2_L:     ofs_q[2] <= {hold_q, cpu_wdata};
          `A_NEXTSEG_L:  nextseg_q <= {hold_q, cpu_wdata};
          `A_NEXTSEGCNT: nextsegcnt_q <= cpu_wdata;
          `A_RELFLAGS:   relflags_q <= cpu_wdata;
          `A_BOFS_L:     bofs_q <= {hold_q, cpu_wdata};
          `A_BCNT_L:     bcnt_q <= {hold_q[3:0], cpu_wdata};
          `A_RELSEG_L:   relseg_q <= {hold_q, cpu_wdata};
          `A_RELOADCNT:  reloadcnt_q <= cpu_wdata;
          `A_HOST_CONFIG_ONE:    hiconf_q <= cpu_wdata;
          `A_TRANSFER_CONTROL_REGISTER:      transfer_control_register_q <= cpu_wdata;
          `A_CONFIG:     config_q <= cpu_wdata;
          default:       ;
        endcase
      end
      // sequencer
      case (st_q)
        S_IDLE: begin
          // start one programmed part [RULE7]
          if (cpu_wr && cpu_addr == `A_HOSTBLOCK && cpu_wdata[0]) begin
            ext_q <= 2'd0;
            st_q  <= S_FORM;
          end
        end
        S_FORM: begin
          // fetch header byte 12 of current segment for the form bit [RULE4]
          if (ph_q == 2'd0) begin
            buf_addr <= {curseg_q, 11'h000} + {{(BUF_AW-12){1'b0}}, `FORM_OFS};
            buf_rd <= 1'b1;
            ph_q <= 2'd1;
          end else begin
            form_q <= buf_rdata[0];
            ph_q <= 2'd0;
            // conditional check on the extent's high byte [RULE2] [RULE3]
            if (!ext_ofs[8+`B_AUTOFORM] || (buf_rdata[0] == ext_ofs[8+`B_FORM])) begin
              bofs_q <= {4'h0, ext_ofs[11:0]};
              st_q <= S_XFER;
            end else begin
              curseg_q <= relseg_q[12:0];
              chan_q <= relseg_q[15:14];
              cursegcnt_q <= nextsegcnt_q;
              st_q <= S_IDLE;
            end
          end
        end
        S_XFER: begin
          if (!dma_on) begin
            dmack <= 1'b0;                                          // [RULE12]
            dma_read_strobe <= 1'b0;
            ph_q <= 2'd0;
          end else if (bcnt_q == 12'h000) begin
            dmack <= 1'b0;
            dma_read_strobe <= 1'b0;
            part_done <= 1'b1;
            ph_q <= 2'd0;
            st_q <= S_NEXT;
          end else if (ph_q == 2'd0) begin
            if (rq_s2_q) begin
              buf_addr <= {curseg_q, 11'h000} + {{(BUF_AW-16){1'b0}}, bofs_q};
              buf_rd <= 1'b1;
              dmack <= 1'b1;                                        // [RULE14] [RULE15]
              ph_q <= 2'd1;
            end else if (!burst) begin
              dmack <= 1'b0;
            end
          end else if (ph_q == 2'd1) begin
            dma_read_strobe <= 1'b1;                                // byte valid [RULE15]
            ph_q <= 2'd2;
          end else begin
            dma_read_strobe <= 1'b0;
            if (!burst)
              dmack <= 1'b0;                                        // one ack per byte [RULE14]
            bofs_q <= bofs_q + 16'h0001;
            bcnt_q <= bcnt_q - 12'h001;
            ph_q <= 2'd0;
          end
        end
        S_NEXT: begin
          // step through extents chosen by chan [RULE1]
          if (ext_q < chan_q && (ext_q != 2'd2 || ext3_ok)) begin
            ext_q <= ext_q + 2'd1;
            bcnt_q <= 12'hFFF & {4'h0, 8'hFF};
            st_q <= S_FORM;
          end else begin
            if (reloadcnt_q != 8'h00)
              reloadcnt_q <= reloadcnt_q - 8'h01;
            // automatic pointer reload at zero count [RULE5] [RULE6]
            if (reloadcnt_q == 8'h01 && relflags_q[`B_REL1:`B_REL2] != 2'b00) begin
              cursegcnt_q <= nextsegcnt_q;
              relseg_q <= nextseg_q;
              relflags_q[`B_REL1] <= 1'b0;
            end
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
      dma_write_strobe <= 1'b0;
    end
  end
endmodule // host_dma_extent_sequencer
`default_nettype wire

/* File: host_dma_extent_sequencer_asserts.sv */
// port assertions for the host dma extent sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_port_checker (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_rdata,
  input wire logic        scsi_cs_n,
  input wire logic        dmarq,
  input wire logic        dmack,
  input wire logic        dma_read_strobe,
  input wire logic        buf_rd
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // any access inside the external controller window
  wire win = (cpu_rd | cpu_wr) && cpu_addr >= 16'hFFC0 && cpu_addr <= 16'hFFDF;
  property p_cs_on; win |=> !scsi_cs_n; endproperty
  a_cs_on: assert property (p_cs_on) else $error("select missing");
  property p_cs_off; !win |=> scsi_cs_n; endproperty
  a_cs_off: assert property (p_cs_off) else $error("stray select");
  property p_hold;
    cpu_wr && cpu_addr == 16'hFF6F ##2 cpu_rd && cpu_addr == 16'hFF6F
      |=> cpu_rdata == $past(cpu_wdata, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("holding byte lost");
  property p_stb_ack; dma_read_strobe |-> dmack; endproperty
  a_stb_ack: assert property (p_stb_ack) else $error("strobe without ack");
  property p_stb_pulse; dma_read_strobe |=> !dma_read_strobe; endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
  // header fetch pulses buf_rd without ack; a halt drops ack with the strobe
  property p_buf_stb; buf_rd && dmack |=> dma_read_strobe || !dmack; endproperty
  a_buf_stb: assert property (p_buf_stb) else $error("byte not strobed");
  property p_req; !dmarq [*4] |-> !(buf_rd && dmack); endproperty
  a_req: assert property (p_req) else $error("byte without request");
  property p_rd_stand; !cpu_rd |=> $stable(cpu_rdata); endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  property p_halt;
    cpu_wr && cpu_addr == 16'hFF6D && !cpu_wdata[7] |-> ##6 !buf_rd [*8];
  endproperty
  a_halt: assert property (p_halt) else $error("dma not halted");
  // main scenarios reached
  c_win: cover property (win);
  c_stb: cover property (dma_read_strobe && dmack);
  c_halt: cover property (cpu_wr && cpu_addr == 16'hFF6D);
endmodule // seq_port_checker
bind host_dma_extent_sequencer seq_port_checker u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata), .scsi_cs_n(scsi_cs_n), .dmarq(dmarq), .dmack(dmack),
  .dma_read_strobe(dma_read_strobe), .buf_rd(buf_rd));
`default_nettype wire

/* File: scsi_dma_requester.sv */
// external controller model: requests bytes, counts strobes and acknowledges
`timescale 1ns/1ps
`default_nettype none
module scsi_dma_requester (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       req_en,   // bench wants data
  input  wire logic       slow,     // pause after each byte
  input  wire logic       dmack,
  input  wire logic       dma_read_strobe,
  output wire logic       dmarq,
  output var  logic [7:0] n_stb,    // bytes strobed
  output var  logic [7:0] n_ack     // acknowledge rising edges
);
  logic       ack_q;  // last acknowledge level
  logic [1:0] gap_q;  // pause left when slow
  // count bytes and ack edges, open a pause after each byte when slow
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      gap_q <= 2'h0;
      n_stb <= 8'h00;
      n_ack <= 8'h00;
    end else begin
      ack_q <= dmack;
      if (dmack && !ack_q) n_ack <= n_ack + 8'h01;
      if (dma_read_strobe) begin
        n_stb <= n_stb + 8'h01;
        gap_q <= slow ? 2'h3 : 2'h0;
      end else if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
    end
  end
  // request stays up while wanted and not pausing
  assign dmarq = req_en && gap_q == 2'h0;
endmodule // scsi_dma_requester
`default_nettype wire

/* File: tb_host_dma_extent_sequencer.sv */
// self-checking bench for the host dma extent sequencer
`timescale 1ns/1ps
`default_nettype none
`include "host_dma_extent_sequencer_map.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_host_dma_extent_sequencer;
  logic        clk_sys, nrst, cpu_wr, cpu_rd, req_en, slow, form_bit, cs_v;
  logic        scsi_cs_n, dmarq, dmack, rstb, wstb, buf_rd, part_done;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, buf_rdata, n_stb, n_ack, rd_v, b0, a0;
  logic [23:0] buf_addr;
  int          fails, compares, dones;
  // buffer: header byte 12 carries the form bit in its lsb
  assign buf_rdata = (buf_addr[11:0] == 12'h00C) ? {7'h00, form_bit} : buf_addr[7:0];
  host_dma_extent_sequencer uut (.clk_sys(clk_sys), .nrst(nrst), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .scsi_cs_n(scsi_cs_n), .dmarq(dmarq), .dmack(dmack), .dma_read_strobe(rstb),
    .dma_write_strobe(wstb), .buf_rd(buf_rd), .buf_addr(buf_addr),
    .buf_rdata(buf_rdata), .part_done(part_done));
  scsi_dma_requester u_far (.clk_sys(clk_sys), .nrst(nrst), .req_en(req_en), .slow(slow),
    .dmack(dmack), .dma_read_strobe(rstb), .dmarq(dmarq), .n_stb(n_stb), .n_ack(n_ack));
  // clock at 125 MHz
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // count finished parts
  always @(posedge clk_sys) if (part_done === 1'b1) dones++;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1;
    rd_v = cpu_rdata;
    cs_v = scsi_cs_n;
  endtask
  // program one part and start it, then wait for its end within lim cycles
  task automatic part(input logic [7:0] mode, cnt, ofs_hi, input int lim);
    int d0;
    wr(`A_TRANSFER_CONTROL_REGISTER, mode);
    wr(`A_HOST_CONFIG_ONE, 8'h80);
    wr(`A_BCNT_H, 8'h00);
    wr(`A_BCNT_L, cnt);
    wr(`A_BOFS_H, ofs_hi);
    wr(`A_BOFS_L, 8'h10);
    wr(`A_OFS0_H, ofs_hi);
    wr(`A_OFS0_L, 8'h10);
    b0 = n_stb;
    a0 = n_ack;
    d0 = dones;
    wr(`A_HOSTBLOCK, 8'h01);
    for (int k = 0; k < lim && dones == d0; k++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic results();
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results();
  end
  initial begin
    logic [15:0] ca [4] = '{16'hFFBF, 16'hFFC0, 16'hFFDF, 16'hFFE0};
    logic [7:0]  fo [3] = '{8'h00, 8'hC0, 8'hC0};
    {nrst, cpu_wr, cpu_rd, req_en, slow, form_bit} = 6'h00;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    `CHK("cs_rst", 1'b1, scsi_cs_n)
    wr(`A_CONFIG, `CFG_8BIT);
    wr(`A_HOLD, 8'h5A);
    rd(`A_HOLD);
    `CHK("hold", 8'h5A, rd_v)
    wr(`A_BCNT_H, 8'h01);
    rd(`A_HOLD);
    `CHK("hi_held", 8'h01, rd_v)
    wr(`A_BCNT_L, 8'h23);
    rd(`A_BCNT_H);
    `CHK("cnt_hi", 8'h01, rd_v)
    wr(`A_NEXTSEGCNT, 8'h33);
    rd(`A_HOLD);
    `CHK("hold_shared", 8'h33, rd_v)
    wr(`A_HOLD, 8'h23);
    rd(`A_BCNT_L);
    `CHK("cnt_lo", 8'h23, rd_v)
    for (int i = 0; i < 4; i++) begin
      rd(ca[i]);
      `CHK("cs", (i == 1 || i == 2) ? 1'b0 : 1'b1, cs_v)
    end
    wr(`A_CURSEG_H, 8'h00);
    wr(`A_CURSEG_L, 8'h01);
    wr(`A_CURSEGCNT, 8'h01);
    req_en <= 1'b1;
    part(8'h20, 8'h03, 8'h00, 300);
    `CHK("normal_bytes", 8'h03, n_stb - b0)
    `CHK("normal_acks", 8'h03, n_ack - a0)
    `CHK("parts", 1, dones)
    `CHK("wstb", 1'b0, wstb)
    slow <= 1'b1;
    part(8'h60, 8'h04, 8'h00, 300);
    `CHK("burst_bytes", 8'h04, n_stb - b0)
    `CHK("burst_acks", 8'h01, n_ack - a0)
    slow <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      form_bit <= (i == 2);
      part(8'h20, 8'h02, fo[i], 300);
      `CHK("form", (i == 1) ? 8'h00 : 8'h02, n_stb - b0)
    end
    slow <= 1'b1;
    part(8'h20, 8'h40, 8'h00, 60);
    wr(`A_HOST_CONFIG_ONE, 8'h00);
    repeat (20) @(posedge clk_sys);
    b0 = n_stb;
    repeat (100) @(posedge clk_sys);
    `CHK("halt", 8'h00, n_stb - b0)
    results();
  end
endmodule // tb_host_dma_extent_sequencer
`default_nettype wire
